/* logic/gfm_lane_mul.sv */
// One byte lane of GF(2^m) multiply, combinational
`timescale 1ns/1ps
`include "gfm_regs.svh"

module gfm_lane_mul (
  input  wire logic [`GFM_LANE_W-1:0] a,
  input  wire logic [`GFM_LANE_W-1:0] b,
  input  wire logic [`GFM_LANE_W-1:0] poly,
  input  wire logic [`GFM_SIZE_W-1:0] size_code,
  output logic      [`GFM_LANE_W-1:0] prod
);

  logic [`GFM_LANE_W:0]   acc;
  logic [`GFM_LANE_W-1:0] msk;
  int                     m;

  always_comb begin
    m   = int'(size_code) + 1;
    msk = gfm_pkg::gfm_mask(size_code);
    acc = 9'h000;
    // Horner form keeps the partial product below degree m at each step
    for (int i = `GFM_LANE_W - 1; i >= 0; i--) begin
      if (i < m) begin
        acc = {acc[`GFM_LANE_W-1:0], 1'b0};
        if (acc[m]) begin
          acc = acc ^ ({1'b0, poly & msk} | (9'h001 << m));
        end
        if (b[i]) begin
          acc = acc ^ {1'b0, a & msk};
        end
      end
    end
    prod = acc[`GFM_LANE_W-1:0] & msk;
  end

endmodule

/* logic/gfm_pkg.sv */
// Types and shared field arithmetic of the Galois field multiplier
`include "gfm_regs.svh"

package gfm_pkg;

  typedef enum logic [1:0] {
    GFM_OP_X4     = 2'b01,
    GFM_OP_SINGLE = 2'b10
  } gfm_op_t;

  typedef enum logic [1:0] {
    GFM_TGT_CFG = 2'b01,
    GFM_TGT_SRC = 2'b10
  } gfm_tgt_t;

  typedef struct packed {
    logic [`GFM_SIZE_W-1:0] size_code;
    logic [`GFM_LANE_W-1:0] poly;
  } gfm_cfg_t;

  typedef struct packed {
    logic                   valid;
    gfm_op_t                kind;
    logic [`GFM_WORD_W-1:0] src1;
    logic [`GFM_WORD_W-1:0] src2;
  } gfm_req_t;

  // Size code is m-1, so code 0 keeps one bit
  function automatic logic [`GFM_LANE_W-1:0] gfm_mask(input logic [`GFM_SIZE_W-1:0] sc);
    return 8'hFF >> (`GFM_SIZE_FULL - sc);
  endfunction

endpackage

/* logic/gfm_regs.svh */
// Field positions, reset values and sizes of the Galois field multiplier
`ifndef GFM_REGS_SVH
`define GFM_REGS_SVH

`define GFM_LANE_W        8
`define GFM_LANES         4
`define GFM_WORD_W        32
`define GFM_SIZE_W        3

`define GFM_CFG_POLY_LSB  0
`define GFM_CFG_POLY_MSB  7
`define GFM_CFG_SIZE_LSB  24
`define GFM_CFG_SIZE_MSB  26

`define GFM_SRC_POLY_LSB  0
`define GFM_SRC_POLY_MSB  7

`define GFM_CFG_SIZE_RST  3'h7
`define GFM_CFG_POLY_RST  8'h1D
`define GFM_SRC_POLY_RST  8'h1D
`define GFM_SIZE_FULL     3'h7

`endif

/* logic/gfm_top.sv */
// Galois field multiply datapath with its two control registers
`timescale 1ns/1ps
`include "gfm_regs.svh"

// Behaviour
// - Packed multiply gives four independent byte-lane field products on the multiply unit.
// - Field GF(2^m), m from 1 to 8, with any configured generator polynomial.
// - Packed multiply takes field size and polynomial from the config register.
// - Single multiply takes its polynomial from the separate poly source register.
// - Config register changes only by a move-to-control write.
// - After reset config holds size code 7h and polynomial 1Dh.
// - Packed multiply right after a config write uses the new values.
// - Addition is XOR; multiply is AND/XOR reduced modulo the generator.
// - GF(8) with x^3+x+1: 100 times 100 is 110; times 001 is identity.
module gfm_top (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   mvc_valid,
  input  wire gfm_pkg::gfm_tgt_t      mvc_target,
  input  wire logic [`GFM_WORD_W-1:0] mvc_data,
  input  wire gfm_pkg::gfm_req_t      issue,
  output logic                        res_valid,
  output logic      [`GFM_WORD_W-1:0] res_data,
  output gfm_pkg::gfm_cfg_t           cfg_state,
  output logic      [`GFM_LANE_W-1:0] src_poly_state
);

  // ************************************************************
  // Control registers
  // ************************************************************
  gfm_pkg::gfm_cfg_t      gf_poly_config_reg;
  logic [`GFM_LANE_W-1:0] gf_poly_source_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gf_poly_config_reg.size_code <= `GFM_CFG_SIZE_RST;
      gf_poly_config_reg.poly      <= `GFM_CFG_POLY_RST;
    end else if (mvc_valid && mvc_target == gfm_pkg::GFM_TGT_CFG) begin
      gf_poly_config_reg.size_code <= mvc_data[`GFM_CFG_SIZE_MSB:`GFM_CFG_SIZE_LSB];
      gf_poly_config_reg.poly      <= mvc_data[`GFM_CFG_POLY_MSB:`GFM_CFG_POLY_LSB];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gf_poly_source_reg <= `GFM_SRC_POLY_RST;
    end else if (mvc_valid && mvc_target == gfm_pkg::GFM_TGT_SRC) begin
      gf_poly_source_reg <= mvc_data[`GFM_SRC_POLY_MSB:`GFM_SRC_POLY_LSB];
    end
  end

  assign cfg_state      = gf_poly_config_reg;
  assign src_poly_state = gf_poly_source_reg;

  // ************************************************************
  // Lane datapath
  // ************************************************************
  logic                   is_x4;
  logic                   is_single;
  logic [`GFM_LANE_W-1:0] lane_prod [`GFM_LANES];
  logic [`GFM_LANE_W-1:0] lane0_poly;
  logic [`GFM_SIZE_W-1:0] lane0_size;

  assign is_x4     = issue.valid && issue.kind == gfm_pkg::GFM_OP_X4;
  assign is_single = issue.valid && issue.kind == gfm_pkg::GFM_OP_SINGLE;

  // single multiply reduces by the source register in a full byte field
  assign lane0_poly = is_single ? gf_poly_source_reg : gf_poly_config_reg.poly;
  assign lane0_size = is_single ? `GFM_SIZE_FULL : gf_poly_config_reg.size_code;

  // each lane sees only its own bytes
  for (genvar g = 0; g < `GFM_LANES; g++) begin : g_lane
    if (g == 0) begin : g_first
      gfm_lane_mul u_mul (
        .a         (issue.src1[`GFM_LANE_W-1:0]),
        .b         (issue.src2[`GFM_LANE_W-1:0]),
        .poly      (lane0_poly),
        .size_code (lane0_size),
        .prod      (lane_prod[0])
      );
    end else begin : g_rest
      // packed lanes use the config register
      gfm_lane_mul u_mul (
        .a         (issue.src1[g*`GFM_LANE_W +: `GFM_LANE_W]),
        .b         (issue.src2[g*`GFM_LANE_W +: `GFM_LANE_W]),
        .poly      (gf_poly_config_reg.poly),
        .size_code (gf_poly_config_reg.size_code),
        .prod      (lane_prod[g])
      );
    end
  end

  // ************************************************************
  // Result stage
  // ************************************************************
  // Illegal kind codes are dropped rather than guessed at
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= is_x4 || is_single;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_data <= 32'h00000000;
    end else if (issue.valid) begin
      unique case (issue.kind)
        gfm_pkg::GFM_OP_X4: begin
          res_data <= {lane_prod[3], lane_prod[2], lane_prod[1], lane_prod[0]};
        end
        gfm_pkg::GFM_OP_SINGLE: begin
          res_data <= {24'h000000, lane_prod[0]};
        end
        default: begin
          res_data <= res_data;
        end
      endcase
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  // Reference product: full carry-less product, then long division
  function automatic logic [7:0] gfm_ref(input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] p, input logic [2:0] sc);
    logic [15:0] prd;
    logic [15:0] gen;
    logic [7:0]  msk;
    int          m;
    msk = gfm_pkg::gfm_mask(sc);
    m   = int'(sc) + 1;
    prd = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      if (b[i] && i < m) begin
        prd = prd ^ (16'(a & msk) << i);
      end
    end
    gen = 16'(p & msk) | (16'h0001 << m);
    for (int k = 14; k >= 0; k--) begin
      if (k >= m && prd[k]) begin
        prd = prd ^ (gen << (k - m));
      end
    end
    return prd[7:0] & msk;
  endfunction

  logic [31:0] ref_x4;
  logic [31:0] ref_single;
  logic [31:0] x4_mask;

  always_comb begin
    ref_x4 = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      ref_x4[i*8 +: 8] = gfm_ref(issue.src1[i*8 +: 8], issue.src2[i*8 +: 8],
                                 gf_poly_config_reg.poly, gf_poly_config_reg.size_code);
    end
    ref_single = {24'h000000, gfm_ref(issue.src1[7:0], issue.src2[7:0],
                                      gf_poly_source_reg, `GFM_SIZE_FULL)};
    x4_mask    = {4{gfm_pkg::gfm_mask(gf_poly_config_reg.size_code)}};
  end

  sequence s_cfg_write;
    mvc_valid && mvc_target == gfm_pkg::GFM_TGT_CFG;
  endsequence

  sequence s_x4_issue;
    is_x4;
  endsequence

  a_lane_issue_done: assert property (@(posedge mclk) disable iff (!rst_n)
    s_x4_issue |=> res_valid)
    else $error("packed multiply gave no result");

  // packed result matches reference with config register
  a_x4_result_ref: assert property (@(posedge mclk) disable iff (!rst_n)
    s_x4_issue |=> res_data == $past(ref_x4))
    else $error("packed product wrong");

  a_single_poly_ref: assert property (@(posedge mclk) disable iff (!rst_n)
    is_single |=> res_valid && res_data == $past(ref_single))
    else $error("single product wrong");

  // config changes only after a move-to-control write
  a_cfg_only_mvc: assert property (@(posedge mclk) disable iff (!rst_n)
    !$stable(gf_poly_config_reg) |-> $past(mvc_valid && mvc_target == gfm_pkg::GFM_TGT_CFG))
    else $error("config changed without write");

  // defaults seen right after reset release
  a_reset_default: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> gf_poly_config_reg.size_code == 3'h7 && gf_poly_config_reg.poly == 8'h1D)
    else $error("config reset value wrong");

  // next packet sees the new config
  a_next_packet_cfg: assert property (@(posedge mclk) disable iff (!rst_n)
    s_cfg_write ##1 s_x4_issue |=> res_data[7:0] == gfm_ref($past(issue.src1[7:0]),
      $past(issue.src2[7:0]), $past(mvc_data[7:0], 2), $past(mvc_data[26:24], 2)))
    else $error("packed multiply missed fresh config");

  // multiply by one returns the element
  a_identity_one: assert property (@(posedge mclk) disable iff (!rst_n)
    is_x4 && issue.src2 == 32'h01010101 |=> res_data == $past(issue.src1 & x4_mask))
    else $error("identity product wrong");

  a_gf8_example: assert property (@(posedge mclk) disable iff (!rst_n)
    is_x4 && gf_poly_config_reg == {3'h2, 8'h0B} && issue.src1[7:0] == 8'h04
      && issue.src2[7:0] == 8'h04 |=> res_data[7:0] == 8'h06)
    else $error("GF(8) example wrong");

  // no bits above m in any lane
  a_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
    s_x4_issue |=> (res_data & ~$past(x4_mask)) == 32'h00000000)
    else $error("lane bits above field size set");

endmodule

/* verif/galois_field_multiplier_tb_top.sv */
// Self-checking bench for the Galois field multiply datapath
`timescale 1ns/1ps

module galois_field_multiplier_tb_top;
  localparam gfm_pkg::gfm_op_t  X4  = gfm_pkg::GFM_OP_X4;
  localparam gfm_pkg::gfm_op_t  SG  = gfm_pkg::GFM_OP_SINGLE;
  localparam gfm_pkg::gfm_tgt_t CFG = gfm_pkg::GFM_TGT_CFG;
  localparam gfm_pkg::gfm_tgt_t SRC = gfm_pkg::GFM_TGT_SRC;

  typedef struct packed {
    logic              wr;
    gfm_pkg::gfm_tgt_t tgt;
    logic [31:0]       wdata;
    gfm_pkg::gfm_op_t  kind;
    logic [31:0]       s1;
    logic [31:0]       s2;
    logic [31:0]       exp;
  } gfm_row_t;

  logic              mclk;
  logic              rst_n;
  logic              mvc_valid;
  gfm_pkg::gfm_tgt_t mvc_target;
  logic [31:0]       mvc_data;
  gfm_pkg::gfm_req_t issue;
  logic              res_valid;
  logic [31:0]       res_data;
  gfm_pkg::gfm_cfg_t cfg_state;
  logic [7:0]        src_poly_state;
  gfm_row_t          rows [8];
  int                mismatches;
  int                n_tests;

  gfm_top gfm_top_inst (.mclk(mclk), .rst_n(rst_n), .mvc_valid(mvc_valid),
    .mvc_target(mvc_target), .mvc_data(mvc_data), .issue(issue), .res_valid(res_valid),
    .res_data(res_data), .cfg_state(cfg_state), .src_poly_state(src_poly_state));

  gfm_cpu_model gfm_cpu_model_inst (.mclk(mclk), .mvc_valid(mvc_valid),
    .mvc_target(mvc_target), .mvc_data(mvc_data), .issue(issue));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // Whole run is well under a hundred cycles
  initial begin
    #20000;
    mismatches++;
    summarize();
  end

  initial begin
    rst_n = 1'h0;
    rows[0] = {1'h0, CFG, 32'h0, X4, 32'h80020100, 32'h02800155, 32'h1D1D0100};
    rows[1] = {1'h1, CFG, 32'h0200000B, X4, 32'h04030705, 32'h04070301, 32'h06020205};
    rows[2] = {1'h1, CFG, 32'h00000000, X4, 32'hFF01FE03, 32'h01FF0101, 32'h01010001};
    rows[3] = {1'h1, CFG, 32'h03000003, X4, 32'h08080201, 32'h02080F0F, 32'h030C0D0F};
    rows[4] = {1'h1, SRC, 32'h0000001B, SG, 32'hAA000080, 32'h55000002, 32'h0000001B};
    rows[5] = {1'h0, CFG, 32'h0, X4, 32'h01020408, 32'h08080808, 32'h0803060C};
    rows[6] = {1'h1, CFG, 32'h0200000B, X4, 32'h03020104, 32'h07060504, 32'h02070506};
    rows[7] = {1'h0, CFG, 32'h0, X4, 32'hFF0A0607, 32'h01010101, 32'h07020607};
    repeat (2) @(posedge mclk);
    #1;
    check("cfg_state", {21'h0, cfg_state}, 32'h0000071D);
    check("res_valid", {31'h0, res_valid}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'h1;
    // *****************************
    // Table of ordinary multiplies
    // *****************************
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        gfm_cpu_model_inst.wr(rows[i].tgt, rows[i].wdata);
      end
      gfm_cpu_model_inst.op(rows[i].kind, rows[i].s1, rows[i].s2);
      gfm_cpu_model_inst.idle();
      #1;
      check("res_valid", {31'h0, res_valid}, 32'h1);
      check("res_data", res_data, rows[i].exp);
    end
    check("cfg_state", {21'h0, cfg_state}, 32'h0000020B);
    check("src_poly_state", {24'h0, src_poly_state}, 32'h0000001B);
    // *****************************
    // Refused codes and mid-run reset
    // *****************************
    gfm_cpu_model_inst.wr(gfm_pkg::gfm_tgt_t'(2'h3), 32'h07000011);
    gfm_cpu_model_inst.op(gfm_pkg::gfm_op_t'(2'h0), 32'h01010101, 32'h01010101);
    gfm_cpu_model_inst.idle();
    #1;
    check("res_valid", {31'h0, res_valid}, 32'h0);
    check("res_data", res_data, rows[7].exp);
    check("cfg_state", {21'h0, cfg_state}, 32'h0000020B);
    check("src_poly_state", {24'h0, src_poly_state}, 32'h0000001B);
    @(posedge mclk);
    rst_n <= 1'h0;
    #1;
    check("cfg_state", {21'h0, cfg_state}, 32'h0000071D);
    check("src_poly_state", {24'h0, src_poly_state}, 32'h0000001D);
    check("res_data", res_data, 32'h0);
    check("res_valid", {31'h0, res_valid}, 32'h0);
    @(posedge mclk);
    rst_n <= 1'h1;
    // Defaults must serve the first multiply after a mid-run reset
    gfm_cpu_model_inst.op(X4, rows[0].s1, rows[0].s2);
    gfm_cpu_model_inst.idle();
    #1;
    check("res_valid", {31'h0, res_valid}, 32'h1);
    check("res_data", res_data, rows[0].exp);
    summarize();
  end
endmodule

/* verif/gfm_cpu_model.sv */
// CPU issue model driving control writes and multiply requests
`timescale 1ns/1ps

module gfm_cpu_model (
  input  wire logic          mclk,
  output logic               mvc_valid,
  output gfm_pkg::gfm_tgt_t  mvc_target,
  output logic [31:0]        mvc_data,
  output gfm_pkg::gfm_req_t  issue
);
  initial begin
    mvc_valid = 1'h0;
    mvc_target = gfm_pkg::GFM_TGT_CFG;
    mvc_data = 32'h0;
    issue = '0;
  end

  // Each task releases the other strobe, so requests can run back to back
  task automatic wr(input gfm_pkg::gfm_tgt_t t, input logic [31:0] d);
    @(posedge mclk);
    issue.valid <= 1'h0;
    mvc_valid <= 1'h1;
    mvc_target <= t;
    mvc_data <= d;
  endtask

  // Released data flips so a stale value never passes for a fresh one
  task automatic op(input gfm_pkg::gfm_op_t k, input logic [31:0] a, input logic [31:0] b);
    @(posedge mclk);
    mvc_valid <= 1'h0;
    mvc_data <= ~mvc_data;
    issue <= {1'h1, k, a, b};
  endtask

  task automatic idle();
    @(posedge mclk);
    mvc_valid <= 1'h0;
    mvc_data <= ~mvc_data;
    issue.valid <= 1'h0;
    issue.src1 <= ~issue.src1;
    issue.src2 <= ~issue.src2;
  endtask
endmodule
